/* hdl/board_watchdog.sv */
// Purpose: Software-armed board watchdog with front panel indicator drive
// Assumes: Register port strobes one cycle long, read data the cycle after
// Notes: Cycles per second are a parameter so simulation can shorten the periods
`timescale 1ns/10ps
module board_watchdog #(
    parameter int TICK_CYCLES_P = board_wd_pkg::TICK_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [board_wd_pkg::ADDR_W-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input board_wd_pkg::power_state_t power_state_i,
    input wire logic handle_open_i,
    input wire logic power_fault_i,
    input wire logic gp_red_chipset_output_i,
    input wire logic sata_activity_i,
    input wire logic proc_hot_i,
    output board_wd_pkg::led_color_t power_good_indicator_o,
    output board_wd_pkg::led_color_t general_purpose_indicator_o,
    output board_wd_pkg::led_color_t disk_activity_indicator_o,
    output logic overtemp_indicator_o,
    output logic sys_reset_req_o,
    output logic irq_o
);
    import board_wd_pkg::*;

    logic [7:0] board_control_low_reg;
    logic [7:0] board_control_high_reg;
    logic [1:0] period_sel_reg;
    logic armed_reg;
    logic [31:0] tick_cnt_reg;
    logic [7:0] sec_cnt_reg;
    logic [4:0] rst_pulse_reg;
    logic [1:0] irq_status_reg;
    logic [1:0] irq_enable_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [7:0] period_s;

    wire logic wr_ctrl_low = wr_i && (addr_i == OFS_CTRL_LOW);
    wire logic wr_ctrl_high = wr_i && (addr_i == OFS_CTRL_HIGH);
    wire logic wr_wd_ctrl = wr_i && (addr_i == OFS_WD_CTRL);
    // Each write here is exactly one trigger, data ignored
    wire logic trigger = wr_i && (addr_i == OFS_WD_TRIGGER); // [R16]
    wire logic wr_irq_en = wr_i && (addr_i == OFS_IRQ_ENABLE);
    wire logic wr_irq_clr = wr_i && (addr_i == OFS_IRQ_CLEAR);
    wire logic tick = (tick_cnt_reg == 32'(TICK_CYCLES_P - 1));
    wire logic pulse_active = (rst_pulse_reg != 5'h00);

    always_comb begin
        unique case (period_sel_reg)
            2'h0: period_s = 8'(PERIOD0_S); // [R1]
            2'h1: period_s = 8'(PERIOD1_S);
            2'h2: period_s = 8'(PERIOD2_S);
            2'h3: period_s = 8'(PERIOD3_S);
        endcase
    end

    // Live comparison so a reprogrammed period takes effect at once
    wire logic expire = armed_reg && !trigger && tick && (sec_cnt_reg >= period_s - 8'h01); // [R4] [R6]

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            board_control_low_reg <= CTRL_RESET;
            board_control_high_reg <= CTRL_RESET;
            period_sel_reg <= PERIOD_RESET;
        end else begin
            if (wr_ctrl_low)
                board_control_low_reg <= wdata_i;
            if (wr_ctrl_high)
                board_control_high_reg <= wdata_i;
            if (wr_wd_ctrl)
                period_sel_reg <= wdata_i[1:0]; // [R6]
        end
    end

    // Arming; there is no path back to idle except system reset
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i)
            armed_reg <= 1'b0; // [R2]
        else if (trigger)
            armed_reg <= 1'b1; // [R3] [R5]
    end

    // Timing restarts at every trigger and after each expiry, so one lapse gives one request
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_cnt_reg <= 32'h00000000;
            sec_cnt_reg <= 8'h00;
        end else if (trigger || !armed_reg || expire) begin
            tick_cnt_reg <= 32'h00000000; // [R3] [R4]
            sec_cnt_reg <= 8'h00;
        end else if (tick) begin
            tick_cnt_reg <= 32'h00000000;
            sec_cnt_reg <= (sec_cnt_reg == 8'hFF) ? sec_cnt_reg : sec_cnt_reg + 8'h01;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
        end
    end

    // Stretched reset request; the board reset returns us to idle
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i)
            rst_pulse_reg <= 5'h00;
        else if (expire)
            rst_pulse_reg <= 5'(RESET_PULSE_CYCLES); // [R4]
        else if (pulse_active)
            rst_pulse_reg <= rst_pulse_reg - 5'h01;
    end
    assign sys_reset_req_o = pulse_active;

    // Sticky events; a set in the clear cycle wins
    wire logic [1:0] irq_set = {expire, trigger && !armed_reg};
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_status_reg <= 2'h0;
            irq_enable_reg <= 2'h0;
        end else begin
            irq_status_reg <= (irq_status_reg & ~(wr_irq_clr ? wdata_i[1:0] : 2'h0)) | irq_set;
            if (wr_irq_en)
                irq_enable_reg <= wdata_i[1:0];
        end
    end
    assign irq_o = |(irq_status_reg & irq_enable_reg);

    always_comb begin
        unique case (addr_i)
            OFS_CTRL_LOW: rdata_next = board_control_low_reg;
            OFS_CTRL_HIGH: rdata_next = board_control_high_reg;
            OFS_WD_CTRL: rdata_next = {6'h00, period_sel_reg};
            OFS_STATUS: rdata_next = {4'h0, proc_hot_i, pulse_active, armed_reg, handle_open_i};
            OFS_IRQ_STATUS: rdata_next = {6'h00, irq_status_reg};
            OFS_IRQ_ENABLE: rdata_next = {6'h00, irq_enable_reg};
            default: rdata_next = 8'h00;
        endcase
    end
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i)
            rdata_reg <= 8'h00;
        else
            rdata_reg <= rd_i ? rdata_next : 8'h00;
    end
    assign rdata_o = rdata_reg;

    led_bus_if leds ();

    blink_gen u_blink (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .leds(leds.blinker)
    );

    led_decode u_decode (
        .power_state_i(power_state_i),
        .handle_open_i(handle_open_i),
        .power_fault_i(power_fault_i),
        .sw_failure_indicate_bit_i(board_control_low_reg[BIT_SW_FAIL]), // [R8]
        .gp_green_enable_bit_i(board_control_high_reg[BIT_GP_GREEN]), // [R10]
        .gp_red_chipset_output_i(gp_red_chipset_output_i), // [R11]
        .sata_activity_i(sata_activity_i),
        .leds(leds.producer)
    );

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            power_good_indicator_o <= LED_OFF;
            general_purpose_indicator_o <= LED_OFF;
            disk_activity_indicator_o <= LED_OFF;
            overtemp_indicator_o <= 1'b0;
        end else begin
            power_good_indicator_o <= leds.power_good_indicator;
            general_purpose_indicator_o <= leds.general_purpose_indicator;
            disk_activity_indicator_o <= leds.disk_activity_indicator;
            overtemp_indicator_o <= proc_hot_i; // [R14]
        end
    end
endmodule // board_watchdog

/* hdl/board_wd_pkg.sv */
// Purpose: Constants and types for the board watchdog and front panel indicators
// Assumes: 100 MHz system clock, register port with one-cycle read latency
// Notes: Cycles per second are a parameter of the top module; the periods in seconds are constants here
// Behaviour
// R1 - Four selectable periods: 2, 10, 50, 255 s
// R2 - Watchdog inactive after reset, no boot triggers
// R3 - First trigger arms watchdog and starts timing
// R4 - Trigger gap over period issues system reset
// R5 - Once armed, stays armed until reset
// R6 - Period may change anytime, applies next check
// R7 - Host must trigger within the selected period
// R8 - Failure bit makes power LED blink red
// R9 - Power LED off/green/yellow blink/red by state
// R10 - GP green follows high control bit
// R11 - GP red follows chipset output high
// R12 - Sleep states set power, GP, disk patterns
// R13 - Disk LED blinks on SATA activity in S0
// R14 - Overtemp LED lights on processor throttle
// R15 - Open handle blinks power LED yellow
// R16 - Each trigger-location write is one trigger
package board_wd_pkg;
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFS_CTRL_LOW = 4'h0;
    localparam logic [3:0] OFS_CTRL_HIGH = 4'h1;
    localparam logic [3:0] OFS_WD_CTRL = 4'h2;
    localparam logic [3:0] OFS_WD_TRIGGER = 4'h3;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_IRQ_STATUS = 4'h5;
    localparam logic [3:0] OFS_IRQ_ENABLE = 4'h6;
    localparam logic [3:0] OFS_IRQ_CLEAR = 4'h7;
    localparam int BIT_SW_FAIL = 0;
    localparam int BIT_GP_GREEN = 0;
    localparam int IRQ_ARMED = 0;
    localparam int IRQ_EXPIRED = 1;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [1:0] PERIOD_RESET = 2'h0;
    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_CYCLES = CLK_HZ;
    localparam int BLINK_HALF_MS = 250;
    localparam int BLINK_HALF_CYCLES = BLINK_HALF_MS * (CLK_HZ / 1000);
    localparam int PERIOD0_S = 2;
    localparam int PERIOD1_S = 10;
    localparam int PERIOD2_S = 50;
    localparam int PERIOD3_S = 255;
    localparam int RESET_PULSE_CYCLES = 16;
    typedef enum logic [1:0] {PS_S0, PS_S3, PS_S4, PS_S5} power_state_t;
    typedef enum logic [1:0] {LED_OFF, LED_GREEN, LED_RED, LED_YELLOW} led_color_t;
endpackage

/* hdl/led_bus_if.sv */
// Purpose: Carries blink phase and indicator colours between modules
// Assumes: Single clock domain
// Notes: None
`timescale 1ns/10ps
interface led_bus_if;
    import board_wd_pkg::*;
    logic blink;
    led_color_t power_good_indicator;
    led_color_t general_purpose_indicator;
    led_color_t disk_activity_indicator;
    modport producer (output power_good_indicator, output general_purpose_indicator,
        output disk_activity_indicator, input blink);
    modport blinker (output blink);
    modport consumer (input power_good_indicator, input general_purpose_indicator,
        input disk_activity_indicator, input blink);
endinterface

/* hdl/blink_gen.sv */
// Purpose: Free-running blink phase for indicators
// Assumes: 100 MHz clock
// Notes: Half period set by package constant
`timescale 1ns/10ps
module blink_gen (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    led_bus_if.blinker leds
);
    import board_wd_pkg::*;
    logic [27:0] cnt_reg;
    logic phase_reg;
    wire logic wrap = (cnt_reg == 28'(BLINK_HALF_CYCLES - 1));
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= 28'h0000000;
            phase_reg <= 1'b0;
        end else begin
            cnt_reg <= wrap ? 28'h0000000 : cnt_reg + 28'h0000001;
            phase_reg <= wrap ? ~phase_reg : phase_reg;
        end
    end
    assign leds.blink = phase_reg;
endmodule // blink_gen

/* hdl/led_decode.sv */
// Purpose: Chooses indicator colours from power state, handle and control bits
// Assumes: Inputs synchronous to clk
// Notes: Purely combinational
`timescale 1ns/10ps
module led_decode (
    input board_wd_pkg::power_state_t power_state_i,
    input wire logic handle_open_i,
    input wire logic power_fault_i,
    input wire logic sw_failure_indicate_bit_i,
    input wire logic gp_green_enable_bit_i,
    input wire logic gp_red_chipset_output_i,
    input wire logic sata_activity_i,
    led_bus_if.producer leds
);
    import board_wd_pkg::*;
    wire logic in_sleep = (power_state_i != PS_S0);
    always_comb begin
        if (in_sleep)
            leds.power_good_indicator = LED_OFF; // [R9] [R12]
        else if (sw_failure_indicate_bit_i)
            leds.power_good_indicator = leds.blink ? LED_RED : LED_OFF; // [R8]
        else if (power_fault_i)
            leds.power_good_indicator = LED_RED; // [R9]
        else if (handle_open_i)
            leds.power_good_indicator = leds.blink ? LED_YELLOW : LED_OFF; // [R9] [R15]
        else
            leds.power_good_indicator = LED_GREEN; // [R9]
    end
    always_comb begin
        unique case (power_state_i)
            PS_S5: begin
                leds.general_purpose_indicator = LED_GREEN; // [R12]
                leds.disk_activity_indicator = LED_GREEN;
            end
            PS_S4: begin
                leds.general_purpose_indicator = LED_GREEN; // [R12]
                leds.disk_activity_indicator = LED_OFF;
            end
            PS_S3: begin
                leds.general_purpose_indicator = LED_OFF; // [R12]
                leds.disk_activity_indicator = LED_GREEN;
            end
            PS_S0: begin
                if (gp_green_enable_bit_i && gp_red_chipset_output_i)
                    leds.general_purpose_indicator = LED_YELLOW;
                else if (gp_red_chipset_output_i)
                    leds.general_purpose_indicator = LED_RED; // [R11]
                else if (gp_green_enable_bit_i)
                    leds.general_purpose_indicator = LED_GREEN; // [R10]
                else
                    leds.general_purpose_indicator = LED_OFF;
                leds.disk_activity_indicator = (sata_activity_i && leds.blink) ? LED_GREEN : LED_OFF; // [R13]
            end
        endcase
    end
endmodule // led_decode

/* testbench/wd_properties.sv */
// Purpose: Port-level checks on the board watchdog
// Assumes: One clock, TICK_CYCLES_P cycles per second
// Notes: Bound to every board_watchdog instance
`timescale 1ns/10ps
module wd_properties #(
    parameter int TICK_CYCLES_P = 10
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [board_wd_pkg::ADDR_W-1:0] addr_i,
    input wire logic wr_i,
    input board_wd_pkg::power_state_t power_state_i,
    input wire logic proc_hot_i,
    input board_wd_pkg::led_color_t power_good_indicator_o,
    input board_wd_pkg::led_color_t general_purpose_indicator_o,
    input board_wd_pkg::led_color_t disk_activity_indicator_o,
    input wire logic overtemp_indicator_o,
    input wire logic sys_reset_req_o
);
    import board_wd_pkg::*;
    logic armed_reg;
    logic [31:0] gap_reg;
    wire trig_w = wr_i && addr_i == OFS_WD_TRIGGER;
    // Cycles since the last trigger write
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            armed_reg <= 1'b0;
            gap_reg <= 32'h0;
        end else begin
            armed_reg <= armed_reg | trig_w;
            gap_reg <= trig_w ? 32'h0 : gap_reg + 32'h1;
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_hold8; sys_reset_req_o [*8]; endsequence
    property p_no_early; !armed_reg |-> !sys_reset_req_o; endproperty
    a_no_early: assert property (p_no_early) else $error("reset before arming");
    property p_gap_min; $rose(sys_reset_req_o) |-> gap_reg >= 2 * TICK_CYCLES_P - 1; endproperty
    a_gap_min: assert property (p_gap_min) else $error("expiry too early");
    property p_pulse; $rose(sys_reset_req_o) |-> s_hold8 ##1 s_hold8 ##1 !sys_reset_req_o; endproperty
    a_pulse: assert property (p_pulse) else $error("reset pulse length");
    property p_holdoff; trig_w |=> (!$rose(sys_reset_req_o)) [*8]; endproperty
    a_holdoff: assert property (p_holdoff) else $error("expiry right after trigger");
    property p_ot; proc_hot_i |=> overtemp_indicator_o; endproperty
    a_ot: assert property (p_ot) else $error("overtemp indicator dark");
    property p_sleep_pg; power_state_i != PS_S0 |=> power_good_indicator_o == LED_OFF; endproperty
    a_sleep_pg: assert property (p_sleep_pg) else $error("power indicator lit in sleep");
    property p_s5;
        power_state_i == PS_S5 |=> general_purpose_indicator_o == LED_GREEN && disk_activity_indicator_o == LED_GREEN;
    endproperty
    a_s5: assert property (p_s5) else $error("soft-off pattern");
    property p_s3;
        power_state_i == PS_S3 |=> general_purpose_indicator_o == LED_OFF && disk_activity_indicator_o == LED_GREEN;
    endproperty
    a_s3: assert property (p_s3) else $error("standby pattern");
    property p_s4;
        power_state_i == PS_S4 |=> general_purpose_indicator_o == LED_GREEN && disk_activity_indicator_o == LED_OFF;
    endproperty
    a_s4: assert property (p_s4) else $error("hibernate pattern");
endmodule // wd_properties

bind board_watchdog wd_properties #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_wd_properties (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_i(wr_i),
    .power_state_i(power_state_i), .proc_hot_i(proc_hot_i),
    .power_good_indicator_o(power_good_indicator_o),
    .general_purpose_indicator_o(general_purpose_indicator_o),
    .disk_activity_indicator_o(disk_activity_indicator_o),
    .overtemp_indicator_o(overtemp_indicator_o), .sys_reset_req_o(sys_reset_req_o)
);

/* testbench/host_model.sv */
// Purpose: Host software driving the board register port
// Assumes: One-cycle strobes, read data the cycle after the read strobe
// Notes: A trigger is a plain write to the trigger location
`timescale 1ns/10ps
module host_model (
    input wire logic clk_sys_i,
    input wire logic [7:0] rdata_i,
    output logic [board_wd_pkg::ADDR_W-1:0] addr_o = '0,
    output logic [7:0] wdata_o = 8'h00,
    output logic wr_o = 1'b0,
    output logic rd_o = 1'b0
);
    import board_wd_pkg::*;
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_sys_i);
        wr_o <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_sys_i);
        rd_o <= 1'b0;
        #1;
        d = rdata_i;
    endtask
    // Gap is kept below the selected period by the caller
    task automatic kick(input int gap);
        repeat (gap) @(posedge clk_sys_i);
        wr_reg(OFS_WD_TRIGGER, 8'h5A);
    endtask
endmodule // host_model

/* testbench/board_watchdog_bench.sv */
// Purpose: Self-checking bench for the board watchdog
// Assumes: One second shortened to TICK cycles
// Notes: Blink phase is not awaited
`timescale 1ns/10ps
module board_watchdog_bench;
    import board_wd_pkg::*;
    localparam int TICK = 10;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata, rdata;
    logic wr, rd, ot, sys_rst, irq;
    logic handle = 1'b0, fault = 1'b0, gp_red = 1'b0, sata = 1'b0, hot = 1'b0;
    power_state_t ps = PS_S0;
    led_color_t pg, gp, hd;
    int err_total = 0;
    int n_checks = 0;
    host_model u_host_model (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd));
    board_watchdog #(.TICK_CYCLES_P(TICK)) u_board_watchdog (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .power_state_i(ps),
        .handle_open_i(handle), .power_fault_i(fault), .gp_red_chipset_output_i(gp_red),
        .sata_activity_i(sata), .proc_hot_i(hot), .power_good_indicator_o(pg),
        .general_purpose_indicator_o(gp), .disk_activity_indicator_o(hd), .overtemp_indicator_o(ot),
        .sys_reset_req_o(sys_rst), .irq_o(irq));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic do_reset;
        @(posedge clk_sys_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
    endtask
    // Counts cycles until the reset request shows
    task automatic wait_rst(output int n);
        n = 0;
        while (sys_rst !== 1'b1 && n < 3000) begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
    endtask
    task automatic drive(input power_state_t s, input logic h, input logic f, input logic r);
        @(posedge clk_sys_i);
        ps <= s;
        handle <= h;
        fault <= f;
        gp_red <= r;
        repeat (3) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic t_idle;
        logic [7:0] d;
        u_host_model.rd_reg(OFS_STATUS, d);
        chk(d, 8'h00);
        u_host_model.rd_reg(OFS_WD_CTRL, d);
        chk(d, {6'h0, PERIOD_RESET});
        u_host_model.rd_reg(4'hF, d);
        chk(d, 8'h00);
        repeat (300) @(posedge clk_sys_i);
        chk({7'h0, sys_rst}, 8'h00);
    endtask
    task automatic t_period(input logic [1:0] p, input int secs);
        int n;
        do_reset();
        u_host_model.wr_reg(OFS_WD_CTRL, {6'h0, p});
        u_host_model.wr_reg(OFS_IRQ_ENABLE, 8'h03);
        u_host_model.kick(0);
        #1;
        chk({7'h0, irq}, 8'h01);
        u_host_model.wr_reg(OFS_IRQ_CLEAR, 8'h01);
        u_host_model.kick(secs * TICK - 6);
        #1;
        chk({7'h0, irq}, 8'h00);
        wait_rst(n);
        chk({7'h0, n >= secs * TICK - 1 && n <= secs * TICK + 3}, 8'h01);
        chk({7'h0, irq}, 8'h01);
    endtask
    task automatic t_retarget;
        int n;
        logic [7:0] d;
        do_reset();
        u_host_model.wr_reg(OFS_WD_CTRL, 8'h03);
        u_host_model.kick(0);
        repeat (30) @(posedge clk_sys_i);
        u_host_model.wr_reg(OFS_CTRL_LOW, 8'h00);
        u_host_model.wr_reg(OFS_IRQ_CLEAR, 8'hFF);
        u_host_model.rd_reg(OFS_STATUS, d);
        chk(d & 8'h02, 8'h02);
        u_host_model.wr_reg(OFS_WD_CTRL, 8'h00);
        wait_rst(n);
        chk({7'h0, n <= 2 * TICK + 3}, 8'h01);
        repeat (RESET_PULSE_CYCLES - 1) @(posedge clk_sys_i);
        #1;
        chk({7'h0, sys_rst}, 8'h01);
        @(posedge clk_sys_i);
        #1;
        chk({7'h0, sys_rst}, 8'h00);
    endtask
    task automatic t_leds;
        do_reset();
        for (int i = 1; i < 4; i++) begin
            drive(power_state_t'(i), 1'b0, 1'b0, 1'b0);
            chk(8'(pg), 8'(LED_OFF));
            chk(8'(gp), (i == 1) ? 8'(LED_OFF) : 8'(LED_GREEN));
            chk(8'(hd), (i == 2) ? 8'(LED_OFF) : 8'(LED_GREEN));
        end
        drive(PS_S0, 1'b0, 1'b1, 1'b0);
        chk(8'(pg), 8'(LED_RED));
        // Blink sits in its dark half for BLINK_HALF_CYCLES after reset
        drive(PS_S0, 1'b1, 1'b0, 1'b0);
        chk(8'(pg), 8'(LED_OFF));
        u_host_model.wr_reg(OFS_CTRL_LOW, 8'h01);
        drive(PS_S0, 1'b0, 1'b1, 1'b0);
        chk(8'(pg), 8'(LED_OFF));
        u_host_model.wr_reg(OFS_CTRL_LOW, 8'h00);
        drive(PS_S0, 1'b0, 1'b0, 1'b1);
        chk(8'(pg), 8'(LED_GREEN));
        chk(8'(gp), 8'(LED_RED));
        u_host_model.wr_reg(OFS_CTRL_HIGH, 8'h01);
        drive(PS_S0, 1'b0, 1'b0, 1'b0);
        chk(8'(gp), 8'(LED_GREEN));
        @(posedge clk_sys_i);
        hot <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk({7'h0, ot}, 8'h01);
    endtask
    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        #200000;
        err_total++;
        end_of_test();
    end
    initial begin
        do_reset();
        t_idle();
        t_period(2'h0, 2);
        t_period(2'h1, 10);
        t_period(2'h2, 50);
        t_period(2'h3, 255);
        t_retarget();
        t_leds();
        end_of_test();
    end
endmodule // board_watchdog_bench
